// file: rtl/sfc_pkg.sv
// sfc_pkg: offsets, reset values and limits of the synthesizer
// frequency configuration bank.
// assumes byte-wide register access through the serial management port.
package sfc_pkg;

    localparam int          NUM_SYNTH    = 3;
    localparam int          BANK_BYTES   = 24;
    localparam logic [6:0]  BANK_BASE    = 7'h50;
    localparam logic [6:0]  BANK_LAST    = 7'h67;
    localparam int          SYNTH_STRIDE = 8;

    // byte offsets inside one synthesizer slice (multi-byte: msb first)
    localparam int          OFS_BASE_STEP  = 0;
    localparam int          OFS_MULTIPLIER = 2;
    localparam int          OFS_NUMERATOR  = 4;
    localparam int          OFS_DENOM      = 6;

    // absolute offsets of the coined registers
    localparam logic [6:0]  PLL0_BASE_STEP       = 7'h50;
    localparam logic [6:0]  PLL0_STEP_MULTIPLIER = 7'h52;
    localparam logic [6:0]  PLL0_FEC_RATIO       = 7'h54;
    localparam logic [6:0]  PLL1_BASE_STEP       = 7'h58;
    localparam logic [6:0]  PLL1_STEP_MULTIPLIER = 7'h5A;
    localparam logic [6:0]  PLL1_FEC_RATIO       = 7'h5C;
    localparam logic [6:0]  PLL2_BASE_STEP       = 7'h60;
    localparam logic [6:0]  PLL2_STEP_MULTIPLIER = 7'h62;
    localparam logic [6:0]  PLL2_FEC_RATIO       = 7'h64;

    // reset values
    localparam logic [15:0] RST_PLL0_BASE_STEP  = 16'h9C40;
    localparam logic [15:0] RST_PLL0_MULTIPLIER = 16'h0798;
    localparam logic [15:0] RST_PLL1_BASE_STEP  = 16'h61A8;
    localparam logic [15:0] RST_PLL1_MULTIPLIER = 16'h0C35;
    localparam logic [15:0] RST_PLL2_BASE_STEP  = 16'h9C40;
    localparam logic [15:0] RST_PLL2_MULTIPLIER = 16'h0798;
    localparam logic [31:0] RST_FEC_RATIO       = 32'h00010001;

    localparam logic [8*BANK_BYTES-1:0] BANK_RESET = {
        RST_PLL0_BASE_STEP, RST_PLL0_MULTIPLIER, RST_FEC_RATIO,
        RST_PLL1_BASE_STEP, RST_PLL1_MULTIPLIER, RST_FEC_RATIO,
        RST_PLL2_BASE_STEP, RST_PLL2_MULTIPLIER, RST_FEC_RATIO};

    // supported base steps in hertz
    localparam logic [15:0] STEP_5K    = 16'h1388;
    localparam logic [15:0] STEP_6K25  = 16'h186A;
    localparam logic [15:0] STEP_8K    = 16'h1F40;
    localparam logic [15:0] STEP_10K   = 16'h2710;
    localparam logic [15:0] STEP_12K5  = 16'h30D4;
    localparam logic [15:0] STEP_25K   = 16'h61A8;
    localparam logic [15:0] STEP_40K   = 16'h9C40;

    // frequency scale factors as shifts: 16 and 8
    localparam int          SHIFT_HIGH = 4;
    localparam int          SHIFT_LOW  = 3;

    // frequency windows in hertz
    localparam logic [31:0] HI_MIN_HZ   = 32'h3B9ACA00; // 1.0 GHz
    localparam logic [31:0] HI_SHARE_HZ = 32'h4190AB00; // 1.1 GHz
    localparam logic [31:0] HI_MAX_HZ   = 32'h59682F00; // 1.5 GHz
    localparam logic [31:0] LO_MIN_HZ   = 32'h1DCD6500; // 500 MHz
    localparam logic [31:0] LO_MAX_HZ   = 32'h2CB41780; // 750 MHz

    localparam int          PROD_W     = 52;
    localparam logic [5:0]  DIV_STEPS  = 6'h33; // PROD_W - 1

endpackage : sfc_pkg

// file: rtl/sfc_freq_calc.sv
// sfc_freq_calc: computes one synthesizer frequency in hertz from
// base step, multiplier and fec ratio, by a serial restoring divider.
// assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sfc_freq_calc #(
    parameter int SHIFT = sfc_pkg::SHIFT_HIGH
) (
    input  wire logic        clock,     // system clock
    input  wire logic        rst_b,     // async reset, active low
    input  wire logic        start,     // begin a new computation
    input  wire logic [15:0] base_step, // base step in hertz
    input  wire logic [15:0] mult,      // step multiplier
    input  wire logic [15:0] num,       // fec numerator
    input  wire logic [15:0] den,       // fec denominator
    output logic             busy,      // computation running
    output logic [31:0]      freq_hz,   // result, saturated
    output logic             freq_valid,// result current
    output logic             div_zero   // denominator was zero
);
    typedef enum logic [1:0] {
        SFC_IDLE = 2'b01,
        SFC_RUN  = 2'b10
    } sfc_calc_state_t;

    sfc_calc_state_t                    state;
    logic [sfc_pkg::PROD_W-1:0]         quot;
    logic [16:0]                        rem;
    logic [5:0]                         cnt;

    wire  [sfc_pkg::PROD_W-1:0] product;
    wire  [16:0]                trial;
    wire                        fits;
    wire  [16:0]                next_rem;
    wire  [sfc_pkg::PROD_W-1:0] next_quot;

    // base * multiplier * factor * numerator, later divided by den
    assign product   = ({36'h0, base_step} * {36'h0, mult} *
                        {36'h0, num}) << SHIFT;
    assign trial     = {rem[15:0], quot[sfc_pkg::PROD_W-1]};
    assign fits      = trial >= {1'b0, den};
    assign next_rem  = fits ? trial - {1'b0, den} : trial;
    assign next_quot = {quot[sfc_pkg::PROD_W-2:0], fits};

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state      <= SFC_IDLE;
            quot       <= '0;
            rem        <= '0;
            cnt        <= '0;
            busy       <= 1'b0;
            freq_hz    <= '0;
            freq_valid <= 1'b0;
            div_zero   <= 1'b0;
        end else begin
            unique case (state)
                SFC_IDLE: begin
                    if (start) begin
                        state      <= SFC_RUN;
                        quot       <= product;
                        rem        <= '0;
                        cnt        <= sfc_pkg::DIV_STEPS;
                        busy       <= 1'b1;
                        freq_valid <= 1'b0;
                        div_zero   <= den == 16'h0000;
                    end
                end
                SFC_RUN: begin
                    quot <= next_quot;
                    rem  <= next_rem;
                    cnt  <= cnt - 6'h01;
                    if (cnt == 6'h00) begin
                        // saturate rather than wrap on out-of-range input
                        freq_hz    <= |next_quot[sfc_pkg::PROD_W-1:32] ?
                                      32'hFFFFFFFF : next_quot[31:0];
                        freq_valid <= 1'b1;
                        busy       <= 1'b0;
                        state      <= SFC_IDLE;
                    end
                end
            endcase
        end
    end
endmodule : sfc_freq_calc
`default_nettype wire

// file: rtl/sfc_regs.sv
// sfc_regs: synthesizer frequency configuration bank, 0x50..0x67,
// with live frequency computation and range status per synthesizer.
// assumes the serial port logic on the same clock presents byte
// accesses as one-cycle strobes with a 7-bit address.
//
// Behaviour
// - base step is a 16-bit hertz value; seven supported settings.
// - synth 0 and 1 frequency = step * multiplier * 16 * num / den.
// - synth 2 uses factor 8 and must stay 500 to 750 MHz.
// - multiplier is 16-bit unsigned in bits 15:0, scales base step.
// - ratio word: denominator bits 15:0, numerator bits 31:16.
// - synth 0 base step resets to 40 kHz, same encoding.
`timescale 1ns/1ps
`default_nettype none
module sfc_regs #(
    parameter int NSYN = sfc_pkg::NUM_SYNTH
) (
    input  wire logic             clock,           // 100 MHz clock
    input  wire logic             rst_b,           // async reset
    input  wire logic [6:0]       reg_addr,        // byte address
    input  wire logic             reg_wr,          // write strobe
    input  wire logic [7:0]       reg_wdata,       // write byte
    input  wire logic             reg_rd,          // read strobe
    output logic      [7:0]       reg_rdata,       // read byte
    output logic      [7:0]       reg_rvalid,      // read answered
    output logic [NSYN-1:0][15:0] base_step_hz,    // per synth step
    output logic [NSYN-1:0][15:0] step_multiplier, // per synth mult
    output logic [NSYN-1:0][15:0] fec_numerator,   // per synth num
    output logic [NSYN-1:0][15:0] fec_denominator, // per synth den
    output logic [NSYN-1:0][31:0] synth_freq_hz,   // computed hz
    output logic [NSYN-1:0]       freq_valid,      // result current
    output logic [NSYN-1:0]       freq_in_range,   // inside window
    output logic [NSYN-1:0]       step_supported,  // listed step
    output logic [NSYN-1:0]       ratio_fault,     // zero den
    output logic                  share_conflict   // 0 and 1 clash
);
    localparam int NB = sfc_pkg::BANK_BYTES;

    logic [7:0]      bank [NB];
    logic [NSYN-1:0] dirty;
    logic [NSYN-1:0] calc_busy;
    logic [NSYN-1:0] calc_valid;

    wire             in_bank;
    wire [6:0]       idx_full;
    wire [4:0]       idx;
    wire [NSYN-1:0]  hit;
    wire [NSYN-1:0]  start;
    wire [NSYN-1:0]  next_range;
    wire [NSYN-1:0]  next_step_ok;
    wire             next_share;

    assign in_bank  = reg_addr >= sfc_pkg::BANK_BASE &&
                      reg_addr <= sfc_pkg::BANK_LAST;
    assign idx_full = reg_addr - sfc_pkg::BANK_BASE;
    assign idx      = idx_full[4:0];

    // byte storage with its reset image; msb of a field at the lower address
    genvar b;
    generate
        for (b = 0; b < NB; b++) begin : g_byte
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    bank[b] <= sfc_pkg::BANK_RESET[8*(NB-1-b) +: 8];
                end else if (reg_wr && in_bank && idx == 5'(b)) begin
                    bank[b] <= reg_wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 8'h00;
        end else begin
            // unmapped addresses read as zero
            reg_rdata  <= (reg_rd && in_bank) ? bank[idx] : 8'h00;
            reg_rvalid <= {7'h00, reg_rd};
        end
    end

    genvar s;
    generate
        for (s = 0; s < NSYN; s++) begin : g_syn
            localparam int O = s * sfc_pkg::SYNTH_STRIDE;
            localparam int SH = (s < 2) ? sfc_pkg::SHIFT_HIGH
                                        : sfc_pkg::SHIFT_LOW;
            localparam logic [31:0] FMIN = (s < 2) ? sfc_pkg::HI_MIN_HZ
                                                   : sfc_pkg::LO_MIN_HZ;
            localparam logic [31:0] FMAX = (s < 2) ? sfc_pkg::HI_MAX_HZ
                                                   : sfc_pkg::LO_MAX_HZ;

            wire [15:0] f_step;
            wire [15:0] f_mult;
            wire [15:0] f_num;
            wire [15:0] f_den;

            assign f_step = {bank[O + sfc_pkg::OFS_BASE_STEP],
                             bank[O + sfc_pkg::OFS_BASE_STEP + 1]};
            assign f_mult = {bank[O + sfc_pkg::OFS_MULTIPLIER],
                             bank[O + sfc_pkg::OFS_MULTIPLIER + 1]};
            assign f_num  = {bank[O + sfc_pkg::OFS_NUMERATOR],
                             bank[O + sfc_pkg::OFS_NUMERATOR + 1]};
            assign f_den  = {bank[O + sfc_pkg::OFS_DENOM],
                             bank[O + sfc_pkg::OFS_DENOM + 1]};

            assign hit[s]   = reg_wr && in_bank &&
                              idx >= 5'(O) &&
                              idx < 5'(O + sfc_pkg::SYNTH_STRIDE);
            assign start[s] = dirty[s] && !calc_busy[s];

            assign next_range[s] = synth_freq_hz[s] >= FMIN &&
                                   synth_freq_hz[s] <= FMAX;
            assign next_step_ok[s] =
                f_step == sfc_pkg::STEP_5K   ||
                f_step == sfc_pkg::STEP_6K25 ||
                f_step == sfc_pkg::STEP_8K   ||
                f_step == sfc_pkg::STEP_10K  ||
                f_step == sfc_pkg::STEP_12K5 ||
                f_step == sfc_pkg::STEP_25K  ||
                f_step == sfc_pkg::STEP_40K;

            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    // compute the reset settings once after release
                    dirty[s]           <= 1'b1;
                    base_step_hz[s]    <= 16'h0000;
                    step_multiplier[s] <= 16'h0000;
                    fec_numerator[s]   <= 16'h0000;
                    fec_denominator[s] <= 16'h0000;
                    freq_in_range[s]   <= 1'b0;
                    step_supported[s]  <= 1'b0;
                    freq_valid[s]      <= 1'b0;
                end else begin
                    // a run that ends with a newer write pending is stale
                    freq_valid[s]      <= calc_valid[s] && !dirty[s] &&
                                          !hit[s];
                    // a write landing with the start keeps it pending
                    dirty[s]           <= hit[s] || (dirty[s] && !start[s]);
                    base_step_hz[s]    <= f_step;
                    step_multiplier[s] <= f_mult;
                    fec_numerator[s]   <= f_num;
                    fec_denominator[s] <= f_den;
                    freq_in_range[s]   <= freq_valid[s] && next_range[s];
                    step_supported[s]  <= next_step_ok[s];
                end
            end

            // product snapshot taken at start, but den is read live, so a later den write can tear a result
            sfc_freq_calc #(
                .SHIFT      (SH)
            ) u_calc (
                .clock      (clock),
                .rst_b      (rst_b),
                .start      (start[s]),
                .base_step  (f_step),
                .mult       (f_mult),
                .num        (f_num),
                .den        (f_den),
                .busy       (calc_busy[s]),
                .freq_hz    (synth_freq_hz[s]),
                .freq_valid (calc_valid[s]),
                .div_zero   (ratio_fault[s])
            );
        end
    endgenerate

    // equal frequencies are only safe from 1.1 GHz upward
    assign next_share = freq_valid[0] && freq_valid[1] &&
                        synth_freq_hz[0] == synth_freq_hz[1] &&
                        synth_freq_hz[0] <  sfc_pkg::HI_SHARE_HZ;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            share_conflict <= 1'b0;
        end else begin
            share_conflict <= next_share;
        end
    end
endmodule : sfc_regs
`default_nettype wire

// file: verification/sfc_regs_props.sv
// sfc_regs_props: concurrent checks on the ports of the config bank.
// assumes one clock domain; attached to sfc_regs by the bind below.
`timescale 1ns/1ps
`default_nettype none
module sfc_regs_props #(
    parameter int NSYN = 3
) (
    input wire logic                  clock,          // clock
    input wire logic                  rst_b,          // reset
    input wire logic [6:0]            reg_addr,       // address
    input wire logic                  reg_wr,         // write
    input wire logic [7:0]            reg_wdata,      // byte in
    input wire logic                  reg_rd,         // read
    input wire logic [7:0]            reg_rdata,      // byte out
    input wire logic [7:0]            reg_rvalid,     // answered
    input wire logic [NSYN-1:0][15:0] base_step_hz,   // steps
    input wire logic [NSYN-1:0][31:0] synth_freq_hz,  // freqs
    input wire logic [NSYN-1:0]       freq_valid,     // current
    input wire logic [NSYN-1:0]       freq_in_range,  // window
    input wire logic [NSYN-1:0]       step_supported, // listed
    input wire logic [NSYN-1:0]       ratio_fault,    // zero den
    input wire logic                  share_conflict  // clash
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire logic mapped = reg_addr >= 7'h50 && reg_addr <= 7'h67;
    wire logic [15:0] s2 = base_step_hz[2];
    wire logic listed = s2 == 16'h1388 || s2 == 16'h186A || s2 == 16'h1F40
        || s2 == 16'h2710 || s2 == 16'h30D4 || s2 == 16'h61A8
        || s2 == 16'h9C40;
    wire logic [31:0] f0 = synth_freq_hz[0];
    wire logic [31:0] f2 = synth_freq_hz[2];
    a_read_answered: assert property (reg_rd |=> reg_rvalid == 8'h01)
        else $error("read strobe not answered next cycle");
    a_read_quiet: assert property (!reg_rd |=> reg_rvalid == 8'h00
        && reg_rdata == 8'h00) else $error("read data outside answer");
    a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 0)
        else $error("unmapped read not zero");
    a_step_copy: assert property (reg_wr && reg_addr == 7'h61 ##1
        !(reg_wr && reg_addr == 7'h61) |=> s2[7:0] == $past(reg_wdata, 2))
        else $error("step byte not copied");
    a_recalc_start: assert property (reg_wr && reg_addr >= 7'h60
        && reg_addr <= 7'h67 |-> ##2 !freq_valid[2])
        else $error("write did not restart computation");
    a_high_window: assert property (freq_valid[0]
        && $past(freq_valid[0]) && $stable(f0) |-> freq_in_range[0] ==
        (f0 >= 32'd1000000000 && f0 <= 32'd1500000000))
        else $error("synth0 range flag wrong");
    a_low_window: assert property (freq_valid[2]
        && $past(freq_valid[2]) && $stable(f2) |-> freq_in_range[2] ==
        (f2 >= 32'd500000000 && f2 <= 32'd750000000))
        else $error("synth2 range flag wrong");
    a_fault_saturates: assert property (freq_valid[1]
        && ratio_fault[1] |-> synth_freq_hz[1] == 32'hFFFFFFFF)
        else $error("zero denominator not saturated");
    a_step_listed: assert property ($stable(s2)
        |-> step_supported[2] == listed) else $error("step flag wrong");
    a_share_flag: assert property ($stable(f0)
        && $stable(synth_freq_hz[1]) && $stable(freq_valid[1:0])
        |-> share_conflict == (&freq_valid[1:0] && f0 == synth_freq_hz[1]
        && f0 < 32'd1100000000)) else $error("share flag wrong");
    c_unmapped: cover property (reg_rd && !mapped);
    c_fault: cover property (ratio_fault[1]);
    c_share: cover property (share_conflict);
endmodule : sfc_regs_props
bind sfc_regs sfc_regs_props #(.NSYN(NSYN)) u_props (.clock(clock),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .base_step_hz(base_step_hz),
    .synth_freq_hz(synth_freq_hz), .freq_valid(freq_valid),
    .freq_in_range(freq_in_range), .step_supported(step_supported),
    .ratio_fault(ratio_fault), .share_conflict(share_conflict));
`default_nettype wire

// file: verification/sfc_regs_tb.sv
// sfc_regs_tb: self-checking bench for the synthesizer config bank.
// assumes byte strobes one cycle wide, driven 1 ns after the edge.
`timescale 1ns/1ps
`default_nettype none
module sfc_regs_tb;
    localparam int NSYN = 3;
    logic clock, rst_b, reg_wr, reg_rd, share_conflict;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, reg_rvalid;
    logic [NSYN-1:0][15:0] base_step_hz, step_multiplier;
    logic [NSYN-1:0][15:0] fec_numerator, fec_denominator;
    logic [NSYN-1:0][31:0] synth_freq_hz;
    logic [NSYN-1:0] freq_valid, freq_in_range, step_supported, ratio_fault;
    int n_fail = 0;
    int total_checks = 0;
    sfc_regs #(.NSYN(NSYN)) u_dut (.clock(clock), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .base_step_hz(base_step_hz), .step_multiplier(step_multiplier),
        .fec_numerator(fec_numerator), .fec_denominator(fec_denominator),
        .synth_freq_hz(synth_freq_hz), .freq_valid(freq_valid),
        .freq_in_range(freq_in_range), .step_supported(step_supported),
        .ratio_fault(ratio_fault), .share_conflict(share_conflict));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clock); #1;
        reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
        @(posedge clock); #1;
        reg_wr = 1'b0;
    endtask : wr
    // msb byte sits at the lower address
    task automatic wr16(input logic [6:0] a, input logic [15:0] d);
        wr(a, d[15:8]);
        wr(a + 7'h01, d[7:0]);
    endtask : wr16
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge clock); #1;
        reg_rd = 1'b1; reg_addr = a;
        @(posedge clock); #1;
        reg_rd = 1'b0;
        check({24'h0, reg_rvalid}, 32'h1);
        check({24'h0, reg_rdata}, {24'h0, exp});
    endtask : rd
    task automatic wait_valid(input int k);
        int i;
        repeat (3) @(posedge clock);
        #1;
        for (i = 0; i < 300 && freq_valid[k] !== 1'b1; i++) @(posedge clock);
        if (i == 300) begin
            n_fail++;
            $display("mismatch at %0t: computation never finished", $time);
            complete_run();
        end
        @(posedge clock); #1;
    endtask : wait_valid
    function automatic logic [31:0] fexp(input logic [15:0] s, m, n, d,
                                         input int sh);
        logic [63:0] q;
        if (d == 16'h0000) return 32'hFFFFFFFF;
        q = ((64'(s) * m * n) << sh) / d;
        return (q > 64'hFFFFFFFF) ? 32'hFFFFFFFF : q[31:0];
    endfunction : fexp
    task automatic t_prog(input int k, input logic [15:0] s, m, n, d);
        logic [6:0] b;
        logic [31:0] f;
        logic ok;
        b = 7'h50 + 7'(k * 8);
        wr16(b, s); wr16(b + 7'h02, m); wr16(b + 7'h04, n); wr16(b + 7'h06, d);
        wait_valid(k);
        f = fexp(s, m, n, d, (k < 2) ? 4 : 3);
        ok = (k < 2) ? (f >= 32'd1000000000 && f <= 32'd1500000000)
                     : (f >= 32'd500000000 && f <= 32'd750000000);
        check(synth_freq_hz[k], f);
        check({16'h0, step_multiplier[k]}, {16'h0, m});
        check({fec_numerator[k], fec_denominator[k]}, {n, d});
        check({31'h0, ratio_fault[k]}, {31'h0, d == 16'h0000});
        check({31'h0, freq_in_range[k]}, {31'h0, ok});
        rd(b + 7'h04, n[15:8]);
    endtask : t_prog
    task automatic t_reset;
        wait_valid(0); wait_valid(1); wait_valid(2);
        for (int i = 0; i < 24; i++)
            rd(7'h50 + 7'(i), sfc_pkg::BANK_RESET[8*(23-i) +: 8]);
        check({16'h0, base_step_hz[0]}, 32'h9C40);
        check({fec_numerator[2], fec_denominator[2]}, 32'h00010001);
        check(synth_freq_hz[0], 32'd1244160000);
        check({31'h0, share_conflict}, 32'h0);
    endtask : t_reset
    task automatic t_unmapped;
        wr(7'h4F, 8'h5A);
        wr(7'h68, 8'hA5);
        rd(7'h4F, 8'h00);
        rd(7'h68, 8'h00);
        rd(7'h67, 8'h01);
    endtask : t_unmapped
    task automatic t_fec;
        t_prog(0, 16'h9C40, 16'h0798, 16'h00FF, 16'h00ED);
        t_prog(2, 16'h1F40, 16'h2000, 16'h0001, 16'h0001);
        t_prog(2, 16'h1F40, 16'h4000, 16'h0001, 16'h0001);
        t_prog(1, 16'h61A8, 16'h0C35, 16'h0001, 16'h0000);
    endtask : t_fec
    task automatic t_share;
        t_prog(0, 16'h1F40, 16'h2000, 16'h0001, 16'h0001);
        t_prog(1, 16'h1F40, 16'h2000, 16'h0001, 16'h0001);
        check({31'h0, share_conflict}, 32'h1);
        t_prog(0, 16'h1F40, 16'h2260, 16'h0001, 16'h0001);
        t_prog(1, 16'h1F40, 16'h2260, 16'h0001, 16'h0001);
        check({31'h0, share_conflict}, 32'h0);
        t_prog(1, 16'h1F40, 16'h2800, 16'h0001, 16'h0001);
        check({31'h0, share_conflict}, 32'h0);
    endtask : t_share
    task automatic t_steps;
        logic [15:0] v [8] = '{16'h1388, 16'h186A, 16'h1F40, 16'h2710,
                               16'h30D4, 16'h61A8, 16'h9C40, 16'h1234};
        for (int i = 0; i < 8; i++) begin
            wr16(7'h60, v[i]);
            repeat (3) @(posedge clock);
            #1;
            check({31'h0, step_supported[2]}, {31'h0, i < 7});
        end
    endtask : t_steps
    initial begin
        rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 7'h00; reg_wdata = 8'h00;
        repeat (3) @(posedge clock);
        #1;
        rst_b = 1'b1;
        t_reset();
        t_unmapped();
        t_fec();
        t_share();
        t_steps();
        complete_run();
    end
endmodule : sfc_regs_tb
`default_nettype wire
